// [design/pbl_pkg.sv]
// Constants, field layouts and carrier types for the start-up loader.
// Assumes a 10 MHz system clock; shared by the loader and its bench.
package pbl_pkg;
    // Timing
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned BOOT_DELAY_NS = 15000;
    localparam int unsigned BOOT_DELAY_MAX_NS = 150000;
    localparam int unsigned BOOT_DLY_CYC = (BOOT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned STRAP_SYNC_CYC = 2;
    // PLL limits in kHz
    localparam int unsigned VCO_MIN_KHZ = 260000;
    localparam int unsigned VCO_MAX_KHZ = 1300000;
    // Boot image check
    localparam logic [31:0] CRC_POLY = 32'hEDB8_8320;
    localparam logic [31:0] CRC_INIT = 32'hFFFF_FFFF;
    localparam logic [31:0] CRC_SKIP = 32'h0D15_AB1E;
    // OTP layout: sector in the top two address bits, row below
    localparam int unsigned OTP_SECTORS = 4;
    localparam int unsigned OTP_ROWS = 512;
    localparam int unsigned OTP_AW = 11;
    localparam logic [10:0] OTP_SEC_ROW = 11'h7FF;
    localparam logic [10:0] OTP_BOOT_ROW = 11'h000;
    // Security register bits
    localparam int unsigned SEC_TEST_DIS = 0;
    localparam int unsigned SEC_LINK_DIS = 1;
    localparam int unsigned SEC_OTP_BOOT = 5;
    localparam int unsigned SEC_REDUND = 7;
    localparam int unsigned SEC_LOCK_LO = 8;
    localparam int unsigned SEC_MASTER = 12;
    localparam int unsigned SEC_TEST_OTP = 13;
    localparam logic [31:0] SEC_SW_MASK = 32'h003F_8000;
    // Register byte offsets
    localparam logic [4:0] REG_PLL = 5'h00;
    localparam logic [4:0] REG_SEC = 5'h04;
    localparam logic [4:0] REG_STATUS = 5'h08;
    localparam logic [4:0] REG_CRC = 5'h0C;
    localparam logic [4:0] REG_FREQ = 5'h10;
    // PLL register fields
    localparam int unsigned PLL_R_LO = 0;
    localparam int unsigned PLL_F_LO = 8;
    localparam int unsigned PLL_OD_LO = 24;
    // Strap-selected settings
    localparam logic [11:0] F_RATIO40 = 12'h09F;
    localparam logic [11:0] F_RATIO16 = 12'h03F;
    localparam logic [11:0] F_RATIO8 = 12'h01F;
    localparam logic [11:0] F_RATIO4 = 12'h00F;
    localparam logic [2:0] OD_STRAP = 3'h1;
    localparam logic [5:0] R_STRAP = 6'h00;

    typedef struct packed {
        logic [2:0] od;
        logic [11:0] f;
        logic [5:0] r;
    } pbl_pll_cfg_t;

    typedef struct packed {
        logic test_port_block;
        logic switch_deny;
        logic otp_redundant_en;
        logic [3:0] otp_sector_lock;
        logic otp_master_lock;
        logic test_otp_block;
    } pbl_sec_out_t;

    typedef enum logic [1:0] {PH_COUNT, PH_PROG, PH_CRC} pbl_phase_t;
    typedef enum logic [2:0] {ST_DELAY, ST_SEC, ST_LOAD, ST_RUN, ST_ERR} pbl_state_t;

    // Strap pair {high, low} to PLL settings
    function automatic pbl_pll_cfg_t pbl_strap_cfg(input logic [1:0] s);
        pbl_pll_cfg_t c;
        c.od = OD_STRAP;
        c.r = R_STRAP;
        case (s)
            2'b00: c.f = F_RATIO40;
            2'b11: c.f = F_RATIO16;
            2'b10: c.f = F_RATIO8;
            default: c.f = F_RATIO4;
        endcase
        return c;
    endfunction
endpackage

// [design/pbl_loader.sv]
// Start-up loader: strap decode, PLL settings, reset sequence, security load and boot image load.
// Assumes on-chip OTP and flash byte sources on clk, an SRAM write port, and an Avalon-MM master.
`timescale 1ns/10ps

// Summary of operation
// - Straps pick ratio, feedback; fixed dividers
// - Tile clock follows the divider formula
// - PLL settings writable through register
// - Reset holds device, pulls GPIO down
// - Boot starts 15 to 150 us later
// - Bit 5 selects OTP boot, else flash
// - Image is count, words, CRC or skip
// - Count and CRC are LSB first
// - Load from RAM bottom, start there
// - CRC covers count and program bytes
// - Reflected 0xEDB88320, init ones, inverted
// - Security loaded from OTP before selection
// - OTP is four sectors of 512 rows
// - OTP content copied and run only when bit 5 set
// - Bit 0 blocks test port, bit 1 switch
// - Bit 7 enables OTP redundant rows
// - Bits 8 to 11 lock sectors
// - Bit 12 locks all OTP programming
// - Bit 13 blocks test port OTP access
module pbl_loader #(
    parameter int unsigned OSC_KHZ = 25000,
    parameter int unsigned RAM_AW = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Strap pins
    input wire logic ratio_strap_high,
    input wire logic ratio_strap_low,
    // Pad control
    output logic gpio_pulldown,
    // PLL control
    output pbl_pkg::pbl_pll_cfg_t pll_cfg,
    // Security controls
    output pbl_pkg::pbl_sec_out_t sec_out,
    // OTP read port
    output logic otp_rd,
    output logic [pbl_pkg::OTP_AW-1:0] otp_addr,
    input wire logic otp_ack,
    input wire logic [31:0] otp_rdata,
    // Flash byte stream
    input wire logic flash_valid,
    input wire logic [7:0] flash_byte,
    output logic flash_ready,
    // SRAM write port
    output logic ram_we,
    output logic [RAM_AW-1:0] ram_addr,
    output logic [31:0] ram_wdata,
    // Processor start
    output logic core_start,
    output logic [RAM_AW-1:0] exec_addr,
    output logic boot_error,
    // Avalon-MM slave
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);
    import pbl_pkg::*;

    localparam logic [31:0] RAM_WORDS = 32'(2 ** RAM_AW);
    localparam logic [RAM_AW-1:0] RAM_BASE = '0;
    localparam logic [7:0] DLY_LAST = 8'(BOOT_DLY_CYC - 1);
    localparam logic [7:0] STRAP_AT = 8'(STRAP_SYNC_CYC);

    if (OSC_KHZ == 0 || OSC_KHZ > 1000000) begin : g_osc_chk
        $error("OSC_KHZ out of range");
    end
    if (RAM_AW < 2 || RAM_AW > 30) begin : g_ram_chk
        $error("RAM_AW out of range");
    end

    function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b);
        logic [31:0] x;
        x = c ^ {24'h00_0000, b};
        for (int i = 0; i < 8; i++) begin
            x = x[0] ? ((x >> 1) ^ CRC_POLY) : (x >> 1);
        end
        return x;
    endfunction

    function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    pbl_state_t state;
    pbl_phase_t phase;
    logic [1:0] strap_s1;
    logic [1:0] strap_s2;
    logic [7:0] dly_cnt;
    logic [31:0] sec;
    logic [31:0] otp_word;
    logic [2:0] otp_left;
    logic [1:0] bcnt;
    logic [31:0] asm_word;
    logic [31:0] crc_acc;
    logic [31:0] words_left;
    logic [RAM_AW-1:0] wr_idx;
    logic [31:0] vco_khz;
    logic [31:0] tile_khz;
    logic pll_range_err;
    logic crc_skipped;
    logic bus_ack;
    logic otp_boot;
    logic otp_want;
    logic byte_take;
    logic [7:0] byte_val;
    logic [31:0] full_word;
    logic word_done;
    logic crc_done;
    logic crc_good;
    logic size_bad;
    logic bus_req;
    logic [31:0] rd_mux;
    logic [31:0] pll_word;
    logic [31:0] pll_new;

    // Pull-downs stay on for the whole reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gpio_pulldown <= 1'b1;
        end else begin
            gpio_pulldown <= 1'b0;
        end
    end

    // Strap synchroniser
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            strap_s1 <= 2'b00;
            strap_s2 <= 2'b00;
        end else begin
            strap_s1 <= {ratio_strap_high, ratio_strap_low};
            strap_s2 <= strap_s1;
        end
    end

    // Internal reset delay before boot
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dly_cnt <= 8'h00;
        end else if (state == ST_DELAY) begin
            dly_cnt <= dly_cnt + 8'h01;
        end
    end

    assign pll_word = {5'h00, pll_cfg.od, 4'h0, pll_cfg.f, 2'h0, pll_cfg.r};
    assign pll_new = be_merge(pll_word, avs_writedata, avs_byteenable);

    // PLL settings: strap value at release, then software
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pll_cfg <= pbl_strap_cfg(2'b00);
        end else if (state == ST_DELAY && dly_cnt == STRAP_AT) begin
            pll_cfg <= pbl_strap_cfg(strap_s2);
        end else if (avs_write && bus_ack && avs_address == REG_PLL) begin
            pll_cfg.r <= pll_new[PLL_R_LO +: 6];
            pll_cfg.f <= pll_new[PLL_F_LO +: 12];
            pll_cfg.od <= pll_new[PLL_OD_LO +: 3];
        end
    end

    // Resulting clock rates and range check
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            vco_khz <= 32'h0000_0000;
            tile_khz <= 32'h0000_0000;
            pll_range_err <= 1'b0;
        end else begin
            vco_khz <= (OSC_KHZ * (32'(pll_cfg.f) + 32'd1)) / (32'd2 * (32'(pll_cfg.r) + 32'd1));
            tile_khz <= vco_khz / (32'(pll_cfg.od) + 32'd1);
            pll_range_err <= vco_khz < VCO_MIN_KHZ || vco_khz > VCO_MAX_KHZ;
        end
    end

    assign otp_boot = sec[SEC_OTP_BOOT];

    always_comb begin
        otp_want = state == ST_SEC || (state == ST_LOAD && otp_boot && otp_left == 3'h0);
        byte_take = state == ST_LOAD && (otp_boot ? otp_left != 3'h0 : flash_valid);
        byte_val = otp_boot ? otp_word[7:0] : flash_byte;
        flash_ready = state == ST_LOAD && !otp_boot;
        full_word = {byte_val, asm_word[31:8]};
        word_done = byte_take && bcnt == 2'h3;
        crc_done = word_done && phase == PH_CRC;
        crc_good = full_word == CRC_SKIP || full_word == ~crc_acc;
        size_bad = word_done && phase == PH_COUNT && full_word > RAM_WORDS;
    end

    // Start-up sequence
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= ST_DELAY;
        end else begin
            case (state)
                ST_DELAY: if (dly_cnt == DLY_LAST) begin
                    state <= ST_SEC;
                end
                ST_SEC: if (otp_ack) begin
                    state <= ST_LOAD;
                end
                ST_LOAD: if (size_bad || (crc_done && !crc_good)) begin
                    state <= ST_ERR;
                end else if (crc_done) begin
                    state <= ST_RUN;
                end
                default: state <= state;
            endcase
        end
    end

    // Security register: OTP image, then software-owned field
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sec <= 32'h0000_0000;
        end else if (state == ST_SEC && otp_ack) begin
            sec <= otp_rdata;
        end else if (avs_write && bus_ack && avs_address == REG_SEC) begin
            sec <= (sec & ~SEC_SW_MASK) | (be_merge(sec, avs_writedata, avs_byteenable) & SEC_SW_MASK);
        end
    end

    // OTP read requests
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            otp_rd <= 1'b0;
            otp_addr <= OTP_BOOT_ROW;
        end else begin
            otp_rd <= otp_rd ? !otp_ack : otp_want;
            if (state == ST_DELAY && dly_cnt == DLY_LAST) begin
                otp_addr <= OTP_SEC_ROW;
            end else if (state == ST_SEC && otp_ack) begin
                otp_addr <= OTP_BOOT_ROW;
            end else if (state == ST_LOAD && otp_ack) begin
                otp_addr <= otp_addr + 11'h001;
            end
        end
    end

    // OTP row split into bytes, low byte first
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            otp_word <= 32'h0000_0000;
            otp_left <= 3'h0;
        end else if (state == ST_LOAD && otp_rd && otp_ack) begin
            otp_word <= otp_rdata;
            otp_left <= 3'h4;
        end else if (byte_take && otp_boot) begin
            otp_word <= otp_word >> 8;
            otp_left <= otp_left - 3'h1;
        end
    end

    // Image parse and check value
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bcnt <= 2'h0;
            asm_word <= 32'h0000_0000;
            crc_acc <= CRC_INIT;
            phase <= PH_COUNT;
            words_left <= 32'h0000_0000;
        end else if (byte_take) begin
            bcnt <= bcnt + 2'h1;
            asm_word <= full_word;
            if (phase != PH_CRC) begin
                crc_acc <= crc_byte(crc_acc, byte_val);
            end
            if (word_done) begin
                case (phase)
                    PH_COUNT: begin
                        words_left <= full_word;
                        phase <= full_word == 32'h0000_0000 ? PH_CRC : PH_PROG;
                    end
                    PH_PROG: begin
                        words_left <= words_left - 32'h0000_0001;
                        if (words_left == 32'h0000_0001) begin
                            phase <= PH_CRC;
                        end
                    end
                    default: phase <= PH_CRC;
                endcase
            end
        end
    end

    // Program words into RAM from the bottom up
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ram_we <= 1'b0;
            ram_addr <= RAM_BASE;
            ram_wdata <= 32'h0000_0000;
            wr_idx <= RAM_BASE;
        end else begin
            ram_we <= word_done && phase == PH_PROG;
            if (word_done && phase == PH_PROG) begin
                ram_addr <= wr_idx;
                ram_wdata <= full_word;
                wr_idx <= wr_idx + 1'b1;
            end
        end
    end

    // Start or refuse the program
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            core_start <= 1'b0;
            exec_addr <= RAM_BASE;
            boot_error <= 1'b0;
            crc_skipped <= 1'b0;
        end else begin
            core_start <= state == ST_LOAD && crc_done && crc_good;
            if (state == ST_LOAD && crc_done) begin
                exec_addr <= RAM_BASE;
                crc_skipped <= full_word == CRC_SKIP;
            end
            if (state == ST_LOAD && (size_bad || (crc_done && !crc_good))) begin
                boot_error <= 1'b1;
            end
        end
    end

    // Security controls
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sec_out <= '0;
        end else begin
            sec_out.test_port_block <= sec[SEC_TEST_DIS];
            sec_out.switch_deny <= sec[SEC_LINK_DIS];
            sec_out.otp_redundant_en <= sec[SEC_REDUND];
            sec_out.otp_sector_lock <= sec[SEC_LOCK_LO +: OTP_SECTORS] | {OTP_SECTORS{sec[SEC_MASTER]}};
            sec_out.otp_master_lock <= sec[SEC_MASTER];
            sec_out.test_otp_block <= sec[SEC_TEST_OTP];
        end
    end

    // Register read mux
    always_comb begin
        case (avs_address)
            REG_PLL: rd_mux = pll_word;
            REG_SEC: rd_mux = sec;
            REG_STATUS: rd_mux = {26'h000_0000, crc_skipped, pll_range_err, otp_boot,
                                  boot_error, state == ST_RUN, state == ST_LOAD};
            REG_CRC: rd_mux = ~crc_acc;
            REG_FREQ: rd_mux = tile_khz;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    assign bus_req = avs_read || avs_write;
    assign avs_waitrequest = bus_req && !bus_ack;

    // One wait cycle per access
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bus_ack <= 1'b0;
            avs_readdata <= 32'h0000_0000;
        end else begin
            bus_ack <= bus_req && !bus_ack;
            if (bus_req && !bus_ack) begin
                avs_readdata <= avs_read ? rd_mux : 32'h0000_0000;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    pulldown_off_a: assert property (!gpio_pulldown |=> !gpio_pulldown)
        else $error("pull-down came back outside reset");
    boot_delay_a: assert property ($fell(state == ST_DELAY) |-> $past(dly_cnt) == DLY_LAST)
        else $error("boot started at wrong delay");
    strap_latch_a: assert property (state == ST_DELAY && dly_cnt == STRAP_AT && !avs_write
                                    |=> pll_cfg == pbl_strap_cfg($past(strap_s2)))
        else $error("strap setting not latched");
    sec_first_a: assert property ($rose(state == ST_LOAD) |-> $past(state) == ST_SEC && $past(otp_ack))
        else $error("boot before security load");
    boot_src_a: assert property (flash_ready |-> !sec[SEC_OTP_BOOT])
        else $error("flash used while OTP boot set");
    exec_base_a: assert property (core_start |-> exec_addr == RAM_BASE && state == ST_RUN)
        else $error("start away from RAM base");
    crc_gate_a: assert property (core_start |-> $past(full_word) == CRC_SKIP
                                 || $past(full_word) == ~$past(crc_acc))
        else $error("program started with bad CRC");
    sector_lock_a: assert property (##1 sec_out.otp_sector_lock
                                    == ($past(sec[11:8]) | {4{$past(sec[SEC_MASTER])}}))
        else $error("sector lock mismatch");
    bus_answer_a: assert property (bus_req && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus answer late");

    flash_boot_c: cover property (core_start && !otp_boot);
    otp_boot_c: cover property (core_start && otp_boot);
    crc_err_c: cover property ($rose(boot_error));
endmodule

// [tb/pbl_mem_model.sv]
// Behavioural OTP array and boot flash byte source for the loader bench.
// Assumes the bench fills otp, fl and fl_n while reset is held.
`timescale 1ns/10ps
module pbl_mem_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // OTP read port
    input wire logic otp_rd,
    input wire logic [10:0] otp_addr,
    output logic otp_ack,
    output logic [31:0] otp_rdata,
    // Flash byte stream
    output logic flash_valid,
    output logic [7:0] flash_byte,
    input wire logic flash_ready
);
    // Four sectors of 512 rows of 32 bits
    logic [31:0] otp [0:2047];
    logic [7:0] fl [0:255];
    int fl_n;
    int fl_i;
    int wait_c;

    // Random answer latency; data changes every idle cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            otp_ack <= 1'b0;
            otp_rdata <= 32'h0000_0000;
            wait_c <= 0;
        end else begin
            otp_ack <= 1'b0;
            otp_rdata <= ~otp_rdata;
            if (otp_rd && !otp_ack) begin
                if (wait_c == 0) begin
                    otp_ack <= 1'b1;
                    otp_rdata <= otp[otp_addr];
                    wait_c <= $urandom_range(0, 3);
                end else begin
                    wait_c <= wait_c - 1;
                end
            end
        end
    end

    // Image bytes in order, LSB first fields, with random stalls
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flash_valid <= 1'b0;
            flash_byte <= 8'h00;
            fl_i <= 0;
        end else if (flash_valid && flash_ready) begin
            fl_i <= fl_i + 1;
            flash_valid <= 1'b0;
            flash_byte <= ~flash_byte;
        end else if (!flash_valid && fl_i < fl_n && $urandom_range(0, 1) == 1) begin
            flash_valid <= 1'b1;
            flash_byte <= fl[fl_i];
        end else if (!flash_valid) begin
            flash_byte <= ~flash_byte;
        end
    end
endmodule

// [tb/pbl_loader_tb.sv]
// Self-checking bench for the start-up loader.
// Assumes pbl_mem_model on the OTP and flash side; registers over Avalon-MM.
`timescale 1ns/10ps
module pbl_loader_tb;
    import pbl_pkg::*;
    logic clk, rst, ratio_strap_high, ratio_strap_low;
    logic otp_rd, otp_ack, flash_valid, flash_ready, ram_we, core_start, boot_error, gpio_pulldown;
    logic [10:0] otp_addr;
    logic [31:0] otp_rdata, ram_wdata, avs_writedata, avs_readdata, q;
    logic [7:0] flash_byte;
    logic [15:0] ram_addr, exec_addr;
    logic [4:0] avs_address;
    logic avs_read, avs_write, avs_waitrequest;
    logic [3:0] avs_byteenable;
    pbl_pll_cfg_t pll_cfg;
    pbl_sec_out_t sec_out;
    logic [15:0] wa[$];
    logic [31:0] wd[$];
    logic [31:0] sec0;
    int n_fail, total_checks, n_start;
    logic [5:0] r;
    logic [11:0] f;
    logic [2:0] od;

    pbl_loader #(.OSC_KHZ(25000), .RAM_AW(16)) u_dut (.clk(clk), .rst(rst),
        .ratio_strap_high(ratio_strap_high), .ratio_strap_low(ratio_strap_low), .gpio_pulldown(gpio_pulldown),
        .pll_cfg(pll_cfg), .sec_out(sec_out), .otp_rd(otp_rd), .otp_addr(otp_addr), .otp_ack(otp_ack),
        .otp_rdata(otp_rdata), .flash_valid(flash_valid), .flash_byte(flash_byte), .flash_ready(flash_ready),
        .ram_we(ram_we), .ram_addr(ram_addr), .ram_wdata(ram_wdata), .core_start(core_start),
        .exec_addr(exec_addr), .boot_error(boot_error), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
    pbl_mem_model u_mem (.clk(clk), .rst(rst), .otp_rd(otp_rd), .otp_addr(otp_addr), .otp_ack(otp_ack),
        .otp_rdata(otp_rdata), .flash_valid(flash_valid), .flash_byte(flash_byte), .flash_ready(flash_ready));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    always @(negedge clk) begin
        if (ram_we === 1'b1) begin
            wa.push_back(ram_addr);
            wd.push_back(ram_wdata);
        end
        if (core_start === 1'b1) n_start++;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Holds the request until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        forever begin
            @(posedge clk);
            n++;
            if (avs_waitrequest === 1'b0) begin
                q = avs_readdata;
                break;
            end
            if (n > 50) begin
                n_fail++;
                $display("ERROR t=%0t bus timeout got=%h exp=%h", $time, avs_waitrequest, 1'b0);
                break;
            end
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    function automatic logic [31:0] crc_upd(input logic [31:0] c, input logic [7:0] b);
        c ^= {24'h00_0000, b};
        for (int i = 0; i < 8; i++) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
        return c;
    endfunction

    // kind: 0 good CRC, 1 skip value, 2 wrong CRC
    task automatic run(input logic [1:0] st, input logic [31:0] sec, input int s, input int kind);
        logic [7:0] img[$];
        logic [31:0] w[$];
        logic [31:0] c, v;
        logic [11:0] fe;
        int n;
        c = CRC_INIT;
        rst <= 1'b1;
        {ratio_strap_high, ratio_strap_low} <= st;
        for (int k = 0; k < 4; k++) img.push_back(8'(s >> (8 * k)));
        for (int j = 0; j < s; j++) begin
            w.push_back($urandom);
            for (int k = 0; k < 4; k++) img.push_back(w[j][8 * k +: 8]);
        end
        foreach (img[k]) c = crc_upd(c, img[k]);
        c = ~c;
        v = kind == 1 ? CRC_SKIP : kind == 2 ? ~c : c;
        for (int k = 0; k < 4; k++) img.push_back(v[8 * k +: 8]);
        u_mem.otp[2047] = sec;
        u_mem.fl_n = sec[5] ? 0 : img.size();
        foreach (img[k]) begin
            u_mem.fl[k] = img[k];
            u_mem.otp[k / 4][8 * (k % 4) +: 8] = img[k];
        end
        repeat (12) @(posedge clk);
        wa = {};
        wd = {};
        n_start = 0;
        chk(gpio_pulldown, 1'b1);
        rst <= 1'b0;
        n = 0;
        while (n_start == 0 && boot_error !== 1'b1 && n < 5000) begin
            @(posedge clk);
            n++;
        end
        @(negedge clk);
        fe = st == 2'b00 ? 12'h09F : st == 2'b01 ? 12'h00F : st == 2'b10 ? 12'h01F : 12'h03F;
        chk(gpio_pulldown, 1'b0);
        chk(n >= 150, 1'b1);
        chk(n_start, kind != 2);
        chk(boot_error, kind == 2);
        chk(exec_addr, 16'h0000);
        chk(pll_cfg, {3'h1, fe, 6'h00});
        chk(sec_out, {sec[0], sec[1], sec[7], sec[11:8] | {4{sec[12]}}, sec[12], sec[13]});
        chk(wa.size(), s);
        foreach (w[j]) begin
            chk(wa[j], j);
            chk(wd[j], w[j]);
        end
        bus(1'b0, REG_STATUS, 32'h0000_0000);
        chk(q[3], sec[5]);
        chk(q[5], kind == 1);
        chk(q[2], kind == 2);
        bus(1'b0, REG_CRC, 32'h0000_0000);
        if (kind != 1) chk(q, c);
    endtask

    task automatic results;
        $display("checks=%0d failures=%0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        #2000000;
        n_fail++;
        results;
    end

    initial begin
        rst = 1'b1;
        {ratio_strap_high, ratio_strap_low} = 2'b00;
        {avs_read, avs_write, avs_address, avs_writedata} = '0;
        avs_byteenable = 4'hF;
        void'($urandom(32'h3cc7_ad8f));
        sec0 = $urandom & 32'hFFFF_FFDF;
        run(2'b00, sec0, 3, 0);
        r = $urandom_range(0, 63);
        f = $urandom_range(0, 4095);
        od = $urandom_range(0, 7);
        bus(1'b1, REG_PLL, {5'h00, od, 4'h0, f, 2'h0, r});
        bus(1'b0, REG_PLL, 32'h0000_0000);
        chk(q, {5'h00, od, 4'h0, f, 2'h0, r});
        chk(pll_cfg, {od, f, r});
        repeat (3) @(posedge clk);
        bus(1'b0, REG_FREQ, 32'h0000_0000);
        chk(q, 25000 * (f + 1) / 2 / (r + 1) / (od + 1));
        avs_byteenable <= 4'h1;
        bus(1'b1, REG_PLL, 32'hFFFF_FFFF);
        avs_byteenable <= 4'hF;
        bus(1'b0, REG_PLL, 32'h0000_0000);
        chk(q, {5'h00, od, 4'h0, f, 2'h0, 6'h3F});
        bus(1'b1, REG_SEC, 32'hFFFF_FFFF);
        bus(1'b0, REG_SEC, 32'h0000_0000);
        chk(q, (sec0 & ~SEC_SW_MASK) | SEC_SW_MASK);
        bus(1'b0, 5'h14, 32'h0000_0000);
        chk(q, 32'h0000_0000);
        run(2'b11, $urandom | 32'h0000_0020, 2, 0);
        run(2'b10, $urandom & 32'hFFFF_FFDF, 0, 1);
        run(2'b01, $urandom & 32'hFFFF_FFDF, 1, 2);
        results;
    end
endmodule
